// file: dv/jfp_port_properties.sv
`timescale 1ns/10ps
// ==========================================
// Port checker
module jfp_port_properties
   import jfp_pkg::*;
(
   // Clocks and reset
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic tck_in,
   // Inputs watched
   input wire logic tms_in,
   input wire logic tdi_in,
   input wire logic ext_reset_n_in,
   input wire logic scan_port_disable_wr_in,
   input wire logic scan_port_disable_wdata_in,
   // Outputs watched
   input wire logic scan_port_disable_bit_out,
   input wire logic scan_port_active_out,
   input wire jfp_cmd_t mem_cmd_out,
   input wire jfp_page_t page_wr_out,
   input wire logic prog_mode_out,
   input wire logic device_reset_out
);
   AST_DIS_WR: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      scan_port_disable_wr_in |=> scan_port_disable_bit_out == $past(scan_port_disable_wdata_in))
      else $error("disable bit write lost");
   AST_GATE: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      scan_port_disable_bit_out |=> !scan_port_active_out)
      else $error("port active while disabled");
   AST_RECLAIM: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      not (scan_port_disable_bit_out && !ext_reset_n_in && !scan_port_disable_wr_in) [*7])
      else $error("disable bit not reclaimed");
   // Guard on past reset: the test clock side leaves reset a few edges late
   AST_CHAIN: assert property (@(posedge tck_in) disable iff (!reset_n_in)
      $changed(device_reset_out) && $past(reset_n_in, 4) |-> device_reset_out == $past(tdi_in))
      else $error("reset chain not from serial input");
   AST_EXEC: assert property (@(posedge tck_in) disable iff (!reset_n_in)
      mem_cmd_out.apply && !$past(tms_in) |=> mem_cmd_out.exec)
      else $error("applied command not executed");
   AST_APPLY_MODE: assert property (@(posedge tck_in) disable iff (!reset_n_in)
      mem_cmd_out.apply |-> prog_mode_out ##1 !mem_cmd_out.apply)
      else $error("apply outside mode or too long");
   AST_WR_MODE: assert property (@(posedge tck_in) disable iff (!reset_n_in)
      page_wr_out.wr |-> prog_mode_out && $stable(page_wr_out.data) ##1 !page_wr_out.wr)
      else $error("page write malformed");
   AST_WR_DUE: assert property (@(posedge tck_in) disable iff (!reset_n_in)
      $changed(page_wr_out.data) && $past(reset_n_in, 4) |-> ##[1:11] page_wr_out.wr)
      else $error("page write late");
endmodule

bind jfp_port jfp_port_properties jfp_port_properties_inst (
   .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .tck_in(tck_in), .tms_in(tms_in),
   .tdi_in(tdi_in), .ext_reset_n_in(ext_reset_n_in),
   .scan_port_disable_wr_in(scan_port_disable_wr_in),
   .scan_port_disable_wdata_in(scan_port_disable_wdata_in),
   .scan_port_disable_bit_out(scan_port_disable_bit_out),
   .scan_port_active_out(scan_port_active_out), .mem_cmd_out(mem_cmd_out),
   .page_wr_out(page_wr_out), .prog_mode_out(prog_mode_out),
   .device_reset_out(device_reset_out));

// file: dv/jfp_prog_model.sv
`timescale 1ns/10ps
// ==========================================
// Scan programmer model
module jfp_prog_model
(
   // Scan pins toward the port
   output logic tck_out,
   output logic tms_out,
   output logic tdi_out,
   input wire logic tdo_in
);
   // Test clock stands low between frames
   initial
   begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b0;
   end

   task automatic tick(input logic tms, input logic tdi, output logic tdo);
      tms_out = tms;
      tdi_out = tdi;
      #3;
      tdo = tdo_in;
      tck_out = 1'b1;
      #3;
      tck_out = 1'b0;
   endtask

   // Outside shifts the data line toggles, so a stale bit never looks valid
   task automatic run(input int n, input logic tms);
      logic b;
      repeat (n) tick(tms, ~tdi_out, b);
   endtask

   task automatic scan(input logic ir, input int w, input logic [15:0] din,
                       output logic [15:0] dout);
      dout = 16'h0000;
      run(ir ? 2 : 1, 1'b1);
      run(2, 1'b0);
      for (int i = 0; i < w; i++)
      begin
         tick(i == w - 1, din[i], dout[i]);
      end
      run(1, 1'b1);
      run(3, 1'b0);
   endtask
endmodule

// file: dv/tb_jfp_port.sv
`timescale 1ns/10ps
`include "jfp_defines.svh"
module tb_jfp_port;
   import jfp_pkg::*;
   // ==========================================
   // Signals
   logic ref_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic scan_port_enable_fuse_in = 1'b1;
   logic ext_reset_n_in = 1'b1;
   logic scan_port_disable_wr_in = 1'b0;
   logic scan_port_disable_wdata_in = 1'b0;
   logic [`JFP_CMD_W-1:0] mem_result_in = 15'h2A5B;
   logic [`JFP_WORD_W-1:0] mem_rdata_in = 16'hC35A;
   logic [15:0] mem_addr_in = 16'h0040;
   logic tck_in, tms_in, tdi_in, tdo_out, tdo_drive_n_out, prog_mode_out, device_reset_out;
   logic scan_port_disable_bit_out, scan_port_active_out;
   logic [15:0] word_addr_out, dout;
   logic [7:0] lb [3] = '{8'hA1, 8'hB2, 8'hC3};
   jfp_cmd_t mem_cmd_out;
   jfp_page_t page_wr_out;
   int n_fail = 0;
   int checks = 0;
   int cyc = 0;
   int n_wr = 0;
   int n_exec = 0;

   jfp_port jfp_port_inst (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
      .tck_in(tck_in), .tms_in(tms_in), .tdi_in(tdi_in), .tdo_out(tdo_out),
      .tdo_drive_n_out(tdo_drive_n_out), .scan_port_enable_fuse_in(scan_port_enable_fuse_in),
      .ext_reset_n_in(ext_reset_n_in), .scan_port_disable_wr_in(scan_port_disable_wr_in),
      .scan_port_disable_wdata_in(scan_port_disable_wdata_in),
      .scan_port_disable_bit_out(scan_port_disable_bit_out),
      .scan_port_active_out(scan_port_active_out), .mem_result_in(mem_result_in),
      .mem_rdata_in(mem_rdata_in), .mem_addr_in(mem_addr_in), .mem_cmd_out(mem_cmd_out),
      .page_wr_out(page_wr_out), .word_addr_out(word_addr_out),
      .prog_mode_out(prog_mode_out), .device_reset_out(device_reset_out));

   // A released line reads inverted so a stale bit cannot pass as data
   wire tdo_pin = tdo_drive_n_out ? ~tdo_out : tdo_out;

   jfp_prog_model jfp_prog_model_inst (.tck_out(tck_in), .tms_out(tms_in),
      .tdi_out(tdi_in), .tdo_in(tdo_pin));

   // ==========================================
   // Tasks
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checks = checks + 1;
      if (got !== exp)
      begin
         n_fail = n_fail + 1;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic sc(input logic ir, input int w, input logic [15:0] din);
      jfp_prog_model_inst.scan(ir, w, din, dout);
   endtask

   task automatic stop_test;
      if (n_fail == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ==========================================
   // Clock, pulse counters and timeout
   initial
   begin
      forever #50 ref_clk_in = ~ref_clk_in;
   end

   // Outputs are unknown before the first reset edges, keep the counts defined
   always @(posedge tck_in)
   begin
      if (page_wr_out.wr === 1'b1)
         n_wr <= n_wr + 1;
      if (mem_cmd_out.exec === 1'b1)
         n_exec <= n_exec + 1;
   end

   always @(posedge ref_clk_in)
   begin
      cyc <= cyc + 1;
      if (cyc == 1000)
      begin
         n_fail = n_fail + 1;
         stop_test();
      end
   end

   // ==========================================
   // Main sequence
   initial
   begin
      @(posedge ref_clk_in);
      jfp_prog_model_inst.run(6, 1'b1);
      @(posedge ref_clk_in);
      reset_n_in <= 1'b1;
      repeat (6) @(posedge ref_clk_in);
      chk("active", 1, scan_port_active_out);
      chk("prog_mode", 0, prog_mode_out);
      chk("drive_n", 1, tdo_drive_n_out);
      scan_port_disable_wr_in <= 1'b1;
      scan_port_disable_wdata_in <= 1'b1;
      @(posedge ref_clk_in);
      scan_port_disable_wr_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      chk("active", 0, scan_port_active_out);
      ext_reset_n_in <= 1'b0;
      repeat (8) @(posedge ref_clk_in);
      chk("disable_bit", 0, scan_port_disable_bit_out);
      ext_reset_n_in <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      jfp_prog_model_inst.run(6, 1'b1);
      jfp_prog_model_inst.run(1, 1'b0);
      sc(1, 4, `JFP_INSTR_RESET);
      chk("ir_capture", `JFP_IR_CAPTURE, dout);
      sc(0, 1, 16'h0001);
      chk("device_reset", 1, device_reset_out);
      sc(1, 4, `JFP_INSTR_ENABLE);
      sc(0, 16, `JFP_SIG_VALUE);
      chk("prog_mode", 1, prog_mode_out);
      sc(1, 4, `JFP_INSTR_CMD);
      sc(0, 15, 16'h1234);
      chk("result", 16'h2A5B, dout);
      chk("cmd", 16'h1234, mem_cmd_out.cmd);
      chk("exec", 1, n_exec);
      sc(1, 4, `JFP_INSTR_LOAD);
      for (int i = 0; i < 3; i++)
      begin
         sc(0, 8, {8'h00, lb[i]});
         chk("page_byte", {6'h00, lb[i], i[0], 1'b0}, {6'h00, page_wr_out});
         chk("word_addr", 16'h0040 + 16'(i / 2), word_addr_out);
      end
      jfp_prog_model_inst.run(12, 1'b0);
      chk("page_writes", 3, n_wr);
      sc(1, 4, `JFP_INSTR_READ);
      sc(0, 8, 16'h0000);
      chk("read_lo", 16'h005A, dout);
      sc(0, 8, 16'h0000);
      chk("read_hi", 16'h00C3, dout);
      chk("word_addr", 16'h0041, word_addr_out);
      sc(1, 4, `JFP_INSTR_ENABLE);
      sc(0, 16, 16'h0000);
      chk("prog_mode", 0, prog_mode_out);
      sc(1, 4, `JFP_INSTR_RESET);
      sc(0, 1, 16'h0000);
      chk("device_reset", 0, device_reset_out);
      @(posedge ref_clk_in);
      scan_port_enable_fuse_in <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
      chk("active", 0, scan_port_active_out);
      stop_test();
   end
endmodule

// file: logic/jfp_defines.svh
`ifndef JFP_DEFINES_SVH
`define JFP_DEFINES_SVH

// ==========================================
// Instruction codes
`define JFP_IR_W 4
`define JFP_INSTR_RESET 4'hC
`define JFP_INSTR_ENABLE 4'h4
`define JFP_INSTR_CMD 4'h5
`define JFP_INSTR_LOAD 4'h6
`define JFP_INSTR_READ 4'h7
`define JFP_INSTR_BYPASS 4'hF
`define JFP_IR_CAPTURE 4'h1

// ==========================================
// Data register layout
`define JFP_SIG_W 16
`define JFP_SIG_VALUE 16'hA370
`define JFP_CMD_W 15
`define JFP_BYTE_W 8
`define JFP_WORD_W 16
`define JFP_CMD_RESET 15'h0000
`define JFP_SIG_RESET 16'h0000

// ==========================================
// Timing, in clock cycles of the named clock
`define JFP_LOAD_TCK 11
`define JFP_JTD_CLR_CLKS 2

`endif

// file: logic/jfp_pkg.sv
package jfp_pkg;
`include "jfp_defines.svh"

   // ==========================================
   // Test controller states
   typedef enum logic [3:0] {
      JFP_TLR = 4'hF,
      JFP_RTI = 4'hC,
      JFP_SEL_DR = 4'h7,
      JFP_CAP_DR = 4'h6,
      JFP_SHIFT_DR = 4'h2,
      JFP_EX1_DR = 4'h1,
      JFP_PAUSE_DR = 4'h3,
      JFP_EX2_DR = 4'h0,
      JFP_UPD_DR = 4'h5,
      JFP_SEL_IR = 4'h4,
      JFP_CAP_IR = 4'hE,
      JFP_SHIFT_IR = 4'hA,
      JFP_EX1_IR = 4'h9,
      JFP_PAUSE_IR = 4'hB,
      JFP_EX2_IR = 4'h8,
      JFP_UPD_IR = 4'hD
   } jfp_tap_t;

   // ==========================================
   // Memory-side carriers
   typedef struct packed {
      logic [`JFP_CMD_W-1:0] cmd;
      logic apply;
      logic exec;
   } jfp_cmd_t;

   typedef struct packed {
      logic [`JFP_BYTE_W-1:0] data;
      logic high;
      logic wr;
   } jfp_page_t;

endpackage

// file: logic/jfp_port.sv
`timescale 1ns/10ps
module jfp_port
   import jfp_pkg::*;
#(
   parameter int ADDR_W = 16
)
(
   // Chip clock and power-on reset
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // Scan pins
   input wire logic tck_in,
   input wire logic tms_in,
   input wire logic tdi_in,
   output logic tdo_out,
   output logic tdo_drive_n_out,
   // Port control
   input wire logic scan_port_enable_fuse_in,
   input wire logic ext_reset_n_in,
   input wire logic scan_port_disable_wr_in,
   input wire logic scan_port_disable_wdata_in,
   output logic scan_port_disable_bit_out,
   output logic scan_port_active_out,
   // Memory side, test clock domain
   input wire logic [`JFP_CMD_W-1:0] mem_result_in,
   input wire logic [`JFP_WORD_W-1:0] mem_rdata_in,
   input wire logic [ADDR_W-1:0] mem_addr_in,
   output jfp_cmd_t mem_cmd_out,
   output jfp_page_t page_wr_out,
   output logic [ADDR_W-1:0] word_addr_out,
   output logic prog_mode_out,
   output logic device_reset_out
);

   // ==========================================
   // Chip clock domain: disable bit and port gate
   localparam logic [1:0] JTD_LAST = 2'(`JFP_JTD_CLR_CLKS - 1);

   logic ext_s1_r;
   logic ext_s2_r;
   logic fuse_s1_r;
   logic fuse_s2_r;
   logic [1:0] jtd_cnt_r;
   logic [1:0] jtd_cnt_nxt;
   logic jtd_nxt;
   logic active_nxt;

   wire ext_low = ~ext_s2_r;
   wire jtd_hold = scan_port_disable_bit_out & ext_low;
   wire jtd_clr = jtd_hold & (jtd_cnt_r == JTD_LAST);

   // Counting restarts whenever the reset pin rises or the bit is clear
   assign jtd_cnt_nxt = jtd_hold ? jtd_cnt_r + 2'h1 : 2'h0;
   // A software write beats the hardware clear in the same cycle
   assign jtd_nxt = scan_port_disable_wr_in ? scan_port_disable_wdata_in
                  : (jtd_clr ? 1'b0 : scan_port_disable_bit_out);
   assign active_nxt = fuse_s2_r & ~scan_port_disable_bit_out;

   always_ff @(posedge ref_clk_in)
   begin
      ext_s1_r <= ext_reset_n_in;
      ext_s2_r <= ext_s1_r;
      fuse_s1_r <= scan_port_enable_fuse_in;
      fuse_s2_r <= fuse_s1_r;
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!reset_n_in)
      begin
         jtd_cnt_r <= 2'h0;
         scan_port_disable_bit_out <= 1'b0;
         scan_port_active_out <= 1'b0;
      end
      else
      begin
         jtd_cnt_r <= jtd_cnt_nxt;
         scan_port_disable_bit_out <= jtd_nxt;
         scan_port_active_out <= active_nxt;
      end
   end

   // ==========================================
   // Test clock domain: crossings and reset
   logic act_s1_r;
   logic act_s2_r;
   logic por_s1_r;
   logic por_s2_r;

   always_ff @(posedge tck_in)
   begin
      act_s1_r <= scan_port_active_out;
      act_s2_r <= act_s1_r;
      por_s1_r <= reset_n_in;
      por_s2_r <= por_s1_r;
   end

   // Power reset only reaches logic while the test clock runs
   wire tck_rst = ~por_s2_r;
   // A disabled port parks the controller in Test-Logic-Reset
   wire tap_rst = tck_rst | ~act_s2_r;

   // ==========================================
   // Test access controller
   jfp_tap_t state_r;
   jfp_tap_t state_nxt;

   always_comb
   begin
      unique case (state_r)
         JFP_TLR: state_nxt = tms_in ? JFP_TLR : JFP_RTI;
         JFP_RTI: state_nxt = tms_in ? JFP_SEL_DR : JFP_RTI;
         JFP_SEL_DR: state_nxt = tms_in ? JFP_SEL_IR : JFP_CAP_DR;
         JFP_CAP_DR: state_nxt = tms_in ? JFP_EX1_DR : JFP_SHIFT_DR;
         JFP_SHIFT_DR: state_nxt = tms_in ? JFP_EX1_DR : JFP_SHIFT_DR;
         JFP_EX1_DR: state_nxt = tms_in ? JFP_UPD_DR : JFP_PAUSE_DR;
         JFP_PAUSE_DR: state_nxt = tms_in ? JFP_EX2_DR : JFP_PAUSE_DR;
         JFP_EX2_DR: state_nxt = tms_in ? JFP_UPD_DR : JFP_SHIFT_DR;
         JFP_UPD_DR: state_nxt = tms_in ? JFP_SEL_DR : JFP_RTI;
         JFP_SEL_IR: state_nxt = tms_in ? JFP_TLR : JFP_CAP_IR;
         JFP_CAP_IR: state_nxt = tms_in ? JFP_EX1_IR : JFP_SHIFT_IR;
         JFP_SHIFT_IR: state_nxt = tms_in ? JFP_EX1_IR : JFP_SHIFT_IR;
         JFP_EX1_IR: state_nxt = tms_in ? JFP_UPD_IR : JFP_PAUSE_IR;
         JFP_PAUSE_IR: state_nxt = tms_in ? JFP_EX2_IR : JFP_PAUSE_IR;
         JFP_EX2_IR: state_nxt = tms_in ? JFP_UPD_IR : JFP_SHIFT_IR;
         JFP_UPD_IR: state_nxt = tms_in ? JFP_SEL_DR : JFP_RTI;
      endcase
   end

   always_ff @(posedge tck_in)
   begin
      if (tap_rst)
         state_r <= JFP_TLR;
      else
         state_r <= state_nxt;
   end

   wire in_tlr = (state_r == JFP_TLR);
   wire in_rti = (state_r == JFP_RTI);
   wire cap_dr = (state_r == JFP_CAP_DR);
   wire sh_dr = (state_r == JFP_SHIFT_DR);
   wire upd_dr = (state_r == JFP_UPD_DR);
   wire cap_ir = (state_r == JFP_CAP_IR);
   wire sh_ir = (state_r == JFP_SHIFT_IR);
   wire upd_ir = (state_r == JFP_UPD_IR);

   // ==========================================
   // Instruction register and decode
   logic [`JFP_IR_W-1:0] ir_sr_r;
   logic [`JFP_IR_W-1:0] ir_r;

   always_ff @(posedge tck_in)
   begin
      if (tap_rst | in_tlr)
      begin
         ir_sr_r <= `JFP_INSTR_BYPASS;
         ir_r <= `JFP_INSTR_BYPASS;
      end
      else
      begin
         if (cap_ir)
            ir_sr_r <= `JFP_IR_CAPTURE;
         else if (sh_ir)
            ir_sr_r <= {tdi_in, ir_sr_r[`JFP_IR_W-1:1]};
         if (upd_ir)
            ir_r <= ir_sr_r;
      end
   end

   wire sel_rst = (ir_r == `JFP_INSTR_RESET);
   wire sel_en = (ir_r == `JFP_INSTR_ENABLE);
   wire sel_cmd = (ir_r == `JFP_INSTR_CMD);
   wire sel_load = (ir_r == `JFP_INSTR_LOAD);
   wire sel_read = (ir_r == `JFP_INSTR_READ);
   wire sel_byte = sel_load | sel_read;
   wire new_byte = (ir_sr_r == `JFP_INSTR_LOAD) | (ir_sr_r == `JFP_INSTR_READ);
   wire page_enter = upd_ir & new_byte;

   // ==========================================
   // Reset chain, enable signature, bypass
   logic [`JFP_SIG_W-1:0] sig_r;
   logic bypass_r;

   wire sig_ok = (sig_r == `JFP_SIG_VALUE);

   // Chain is not cleared by Test-Logic-Reset so the part stays held
   always_ff @(posedge tck_in)
   begin
      if (tck_rst)
      begin
         device_reset_out <= 1'b0;
         sig_r <= `JFP_SIG_RESET;
         prog_mode_out <= 1'b0;
      end
      else
      begin
         if (sh_dr & sel_rst)
            device_reset_out <= tdi_in;
         if (sh_dr & sel_en)
            sig_r <= {tdi_in, sig_r[`JFP_SIG_W-1:1]};
         if (upd_dr & sel_en)
            prog_mode_out <= sig_ok;
      end
   end

   always_ff @(posedge tck_in)
   begin
      if (tap_rst)
         bypass_r <= 1'b0;
      else if (cap_dr)
         bypass_r <= 1'b0;
      else if (sh_dr)
         bypass_r <= tdi_in;
   end

   // ==========================================
   // Command register, page byte in its low bits
   logic [`JFP_CMD_W-1:0] cmd_r;
   logic exec_pend_r;
   logic rd_high_r;
   logic ld_high_r;
   logic ld_first_r;
   logic [3:0] ld_cnt_r;

   localparam logic [3:0] LOAD_CNT = 4'(`JFP_LOAD_TCK);

   wire do_apply = upd_dr & sel_cmd & prog_mode_out;
   wire do_load = upd_dr & sel_load & prog_mode_out;
   wire do_read = cap_dr & sel_read & prog_mode_out;
   wire [`JFP_BYTE_W-1:0] rd_byte = rd_high_r
      ? mem_rdata_in[`JFP_WORD_W-1:`JFP_BYTE_W]
      : mem_rdata_in[`JFP_BYTE_W-1:0];
   wire ld_inc = do_load & ~ld_high_r & ~ld_first_r;
   wire rd_inc = do_read & rd_high_r;
   wire ld_fire = (ld_cnt_r == 4'h1);

   always_ff @(posedge tck_in)
   begin
      if (tap_rst)
         cmd_r <= `JFP_CMD_RESET;
      else if (cap_dr & sel_cmd)
         cmd_r <= mem_result_in;
      else if (do_read)
         cmd_r[`JFP_BYTE_W-1:0] <= rd_byte;
      else if (sh_dr & sel_cmd)
         cmd_r <= {tdi_in, cmd_r[`JFP_CMD_W-1:1]};
      else if (sh_dr & sel_byte)
         cmd_r[`JFP_BYTE_W-1:0] <= {tdi_in, cmd_r[`JFP_BYTE_W-1:1]};
   end

   // Applied command stays on the memory inputs until the next apply or a controller reset, which clears it
   always_ff @(posedge tck_in)
   begin
      if (tap_rst)
      begin
         mem_cmd_out <= '0;
         exec_pend_r <= 1'b0;
      end
      else
      begin
         mem_cmd_out.apply <= do_apply;
         if (do_apply)
            mem_cmd_out.cmd <= cmd_r;
         mem_cmd_out.exec <= in_rti & exec_pend_r;
         if (do_apply)
            exec_pend_r <= 1'b1;
         else if (in_rti)
            exec_pend_r <= 1'b0;
      end
   end

   // ==========================================
   // Page load and read sequencing
   always_ff @(posedge tck_in)
   begin
      if (tap_rst)
      begin
         page_wr_out <= '0;
         ld_cnt_r <= 4'h0;
         ld_high_r <= 1'b0;
         ld_first_r <= 1'b1;
         rd_high_r <= 1'b0;
         word_addr_out <= '0;
      end
      else
      begin
         page_wr_out.wr <= ld_fire;
         if (do_load)
         begin
            page_wr_out.data <= cmd_r[`JFP_BYTE_W-1:0];
            page_wr_out.high <= ld_high_r;
            ld_cnt_r <= LOAD_CNT;
         end
         else if (ld_cnt_r != 4'h0)
            ld_cnt_r <= ld_cnt_r - 4'h1;
         if (page_enter)
         begin
            ld_high_r <= 1'b0;
            ld_first_r <= 1'b1;
            rd_high_r <= 1'b0;
            word_addr_out <= mem_addr_in;
         end
         else
         begin
            if (do_load)
            begin
               ld_high_r <= ~ld_high_r;
               ld_first_r <= 1'b0;
            end
            if (do_read)
               rd_high_r <= ~rd_high_r;
            // Neither loads nor reads are held to the page; both step the word address with no limit
            if (ld_inc | rd_inc)
               word_addr_out <= word_addr_out + ADDR_W'(1);
         end
      end
   end

   // ==========================================
   // Serial output, changed on the falling edge
   logic dr_bit;

   assign dr_bit = sel_rst ? device_reset_out
                 : sel_en ? sig_r[0]
                 : (sel_cmd | sel_byte) ? cmd_r[0]
                 : bypass_r;

   always_ff @(negedge tck_in)
   begin
      if (tap_rst)
      begin
         tdo_out <= 1'b0;
         tdo_drive_n_out <= 1'b1;
      end
      else
      begin
         tdo_out <= sh_ir ? ir_sr_r[0] : dr_bit;
         tdo_drive_n_out <= ~(sh_ir | sh_dr);
      end
   end

endmodule
